// [include/timer_pkg.sv]
// constants of the 8-bit compare timer channel
// assumes a 40 MHz peripheral clock and a 32-bit classic bus slave
package timer_pkg;
    // byte addresses of the registers
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STAT_ADDR = 8'h04;
    localparam logic [7:0] COUNT_ADDR = 8'h08;
    localparam logic [7:0] CONST_A_ADDR = 8'h0C;
    localparam logic [7:0] CONST_B_ADDR = 8'h10;
    localparam logic [7:0] ALT_ADDR = 8'h14;
    // control fields
    localparam int CMP_B_IE_BIT = 7;
    localparam int CMP_A_IE_BIT = 6;
    localparam int OVF_IE_BIT = 5;
    localparam int CLR_SEL_LSB = 3;
    localparam int SRC_SEL_LSB = 0;
    // status fields
    localparam int FLAG_LSB = 5;
    localparam int FLAG_OVF = 0;
    localparam int FLAG_A = 1;
    localparam int FLAG_B = 2;
    localparam int STAT_ONE_BIT = 4;
    localparam int OUT_SEL_LSB = 0;
    localparam int ALT_BIT = 0;
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] CONST_RESET = 8'hFF;
    localparam logic [3:0] OUT_SEL_RESET = 4'h0;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    // count source codes
    localparam logic [2:0] SRC_DIV_LO = 3'h1;
    localparam logic [2:0] SRC_DIV_MID = 3'h2;
    localparam logic [2:0] SRC_DIV_HI = 3'h3;
    localparam logic [2:0] SRC_EXT_RISE = 3'h5;
    localparam logic [2:0] SRC_EXT_FALL = 3'h6;
    localparam logic [2:0] SRC_EXT_BOTH = 3'h7;
    // counter clear codes
    localparam logic [1:0] CLR_NONE = 2'h0;
    localparam logic [1:0] CLR_ON_A = 2'h1;
    localparam logic [1:0] CLR_ON_B = 2'h2;
    localparam logic [1:0] CLR_ON_PIN = 2'h3;
    // output actions
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    // prescaler divisors
    localparam int PRE_WIDTH = 10;
    localparam logic [9:0] DIV_8 = 10'h007;
    localparam logic [9:0] DIV_64 = 10'h03F;
    localparam logic [9:0] DIV_1024 = 10'h3FF;
    localparam logic [9:0] DIV_2 = 10'h001;
    localparam logic [9:0] DIV_32 = 10'h01F;
    localparam logic [9:0] DIV_256 = 10'h0FF;
endpackage : timer_pkg

// [include/prescale_if.sv]
// carrier between the timer core and its prescaler
// assumes both ends run on the same peripheral clock
`timescale 1ns/100ps
`default_nettype none
interface prescale_if;
    logic [2:0] source_sel;
    logic alt_sel;
    logic tick;
    modport gen (input source_sel, input alt_sel, output tick);
    modport user (output source_sel, output alt_sel, input tick);
endinterface : prescale_if
`default_nettype wire

// [rtl/pin_edge_sync.sv]
// three-flop pin synchroniser with rise and fall pulses
// assumes an asynchronous pin and a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module pin_edge_sync
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output logic rise_o,
    output logic fall_o
);
    logic s1, s2, s3, level;
    logic next_level;

    always_comb
    begin
        next_level = level;
        if (s2 == s3)
        begin
            next_level = s3;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level <= 1'b0;
        end
        else
        begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
            level <= next_level;
        end
    end

    assign rise_o = next_level & ~level;
    assign fall_o = ~next_level & level;
endmodule : pin_edge_sync
`default_nettype wire

// [rtl/timer_prescaler.sv]
// free-running prescaler giving falling-edge ticks of the divided clock
// assumes the source and alternate selects come from the timer core
`timescale 1ns/100ps
`default_nettype none
module timer_prescaler
#(
    parameter int WIDTH = timer_pkg::PRE_WIDTH
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    prescale_if.gen pre
);
    logic [WIDTH-1:0] cnt;
    logic [WIDTH-1:0] next_cnt;
    logic [WIDTH-1:0] mask;
    logic active;

    always_comb
    begin
        next_cnt = WIDTH'(cnt + 1'b1);
        active = 1'b1;
        case (pre.source_sel)
            timer_pkg::SRC_DIV_LO:
                mask = pre.alt_sel ? timer_pkg::DIV_2 : timer_pkg::DIV_8;
            timer_pkg::SRC_DIV_MID:
                mask = pre.alt_sel ? timer_pkg::DIV_32 : timer_pkg::DIV_64;
            timer_pkg::SRC_DIV_HI:
                mask = pre.alt_sel ? timer_pkg::DIV_256 : timer_pkg::DIV_1024;
            default:
            begin
                mask = '1;
                active = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt <= '0;
        end
        else
        begin
            cnt <= next_cnt;
        end
    end

    // divided clock falls when its low bits wrap
    assign pre.tick = active && ((cnt & mask) == mask);
endmodule : timer_prescaler
`default_nettype wire

// [rtl/compare_timer.sv]
// one 8-bit compare timer channel with a classic bus register slave
// assumes pins are asynchronous and the bus runs on clk_i
`timescale 1ns/100ps
`default_nettype none
module compare_timer
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ext_clk_i,
    input wire logic ext_reset_i,
    output logic timer_out_o,
    output logic timer_out_oe_n_o,
    output logic irq_overflow_o,
    output logic irq_compare_a_o,
    output logic irq_compare_b_o
);
    ////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0] control, count, const_a, const_b;
    logic [3:0] out_sel;
    logic [2:0] flags, armed;
    logic alt, eq_a_q, eq_b_q, pin_level;
    logic [7:0] next_control, next_count, next_const_a, next_const_b;
    logic [3:0] next_out_sel;
    logic [2:0] next_flags, next_armed, set_evt;
    logic next_alt, next_pin_level, next_ack;
    logic [31:0] next_rdata;

    ////////////////////////////////////////////////////////////////////////
    // sources
    logic ext_rise, ext_fall, rst_rise;
    logic req, wr, rd, eq_a, eq_b, match_a, match_b, tick, clr, cnt_wr;
    logic [2:0] src;
    logic [1:0] clr_sel, act_a, act_b;
    prescale_if pre ();

    pin_edge_sync clk_sync
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(ext_clk_i),
        .rise_o(ext_rise),
        .fall_o(ext_fall)
    );

    pin_edge_sync rst_sync
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(ext_reset_i),
        .rise_o(rst_rise),
        .fall_o()
    );

    timer_prescaler prescaler
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pre(pre.gen)
    );

    assign src = control[timer_pkg::SRC_SEL_LSB +: 3];
    assign clr_sel = control[timer_pkg::CLR_SEL_LSB +: 2];
    assign act_a = out_sel[1:0];
    assign act_b = out_sel[3:2];
    assign pre.source_sel = src;
    assign pre.alt_sel = alt;

    ////////////////////////////////////////////////////////////////////////
    // next values
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign rd = req && !wb_we_i;
    assign eq_a = (count == const_a);
    assign eq_b = (count == const_b);
    assign match_a = eq_a && !eq_a_q;
    assign match_b = eq_b && !eq_b_q;
    assign cnt_wr = wr && (wb_adr_i == timer_pkg::COUNT_ADDR);

    always_comb
    begin
        case (src)
            timer_pkg::SRC_DIV_LO,
            timer_pkg::SRC_DIV_MID,
            timer_pkg::SRC_DIV_HI: tick = pre.tick;
            timer_pkg::SRC_EXT_RISE: tick = ext_rise;
            timer_pkg::SRC_EXT_FALL: tick = ext_fall;
            timer_pkg::SRC_EXT_BOTH: tick = ext_rise | ext_fall;
            default: tick = 1'b0;
        endcase
        case (clr_sel)
            timer_pkg::CLR_ON_A: clr = match_a;
            timer_pkg::CLR_ON_B: clr = match_b;
            timer_pkg::CLR_ON_PIN: clr = rst_rise;
            default: clr = 1'b0;
        endcase
    end

    always_comb
    begin
        next_control = control;
        next_alt = alt;
        next_out_sel = out_sel;
        next_const_a = const_a;
        next_const_b = const_b;
        next_count = count;
        if (cnt_wr)
        begin
            next_count = wb_dat_i[7:0];
        end
        else if (clr)
        begin
            next_count = timer_pkg::COUNT_RESET;
        end
        else if (tick)
        begin
            next_count = 8'(count + 8'h01);
        end
        set_evt = 3'h0;
        set_evt[timer_pkg::FLAG_OVF] = tick && !clr && !cnt_wr
            && (count == timer_pkg::COUNT_MAX);
        set_evt[timer_pkg::FLAG_A] = match_a;
        set_evt[timer_pkg::FLAG_B] = match_b;
        next_flags = flags;
        next_armed = armed;
        for (int i = 0; i < 3; i++)
        begin
            if (rd && wb_adr_i == timer_pkg::STAT_ADDR && flags[i])
            begin
                next_armed[i] = 1'b1;
            end
            // writes only clear, an event in the same cycle wins
            if (wr && wb_adr_i == timer_pkg::STAT_ADDR && armed[i]
                && !wb_dat_i[timer_pkg::FLAG_LSB + i])
            begin
                next_flags[i] = 1'b0;
                next_armed[i] = 1'b0;
            end
            if (set_evt[i])
            begin
                next_flags[i] = 1'b1;
            end
        end
        if (wr)
        begin
            case (wb_adr_i)
                timer_pkg::CTRL_ADDR: next_control = wb_dat_i[7:0];
                timer_pkg::STAT_ADDR:
                    next_out_sel = wb_dat_i[timer_pkg::OUT_SEL_LSB +: 4];
                timer_pkg::CONST_A_ADDR: next_const_a = wb_dat_i[7:0];
                timer_pkg::CONST_B_ADDR: next_const_b = wb_dat_i[7:0];
                timer_pkg::ALT_ADDR: next_alt = wb_dat_i[timer_pkg::ALT_BIT];
                default: next_alt = alt;
            endcase
        end
        next_pin_level = pin_level;
        if (match_a)
        begin
            case (act_a)
                timer_pkg::ACT_LOW: next_pin_level = 1'b0;
                timer_pkg::ACT_HIGH: next_pin_level = 1'b1;
                timer_pkg::ACT_TOGGLE: next_pin_level = !pin_level;
                default: next_pin_level = pin_level;
            endcase
        end
        if (match_b)
        begin
            case (act_b)
                timer_pkg::ACT_LOW: next_pin_level = 1'b0;
                timer_pkg::ACT_HIGH: next_pin_level = 1'b1;
                timer_pkg::ACT_TOGGLE:
                    next_pin_level = !next_pin_level;
                default: next_pin_level = next_pin_level;
            endcase
        end
        next_ack = req;
        next_rdata = 32'h0000_0000;
        if (rd)
        begin
            case (wb_adr_i)
                timer_pkg::CTRL_ADDR: next_rdata[7:0] = control;
                timer_pkg::STAT_ADDR:
                    next_rdata[7:0] = {flags, 1'b1, out_sel};
                timer_pkg::COUNT_ADDR: next_rdata[7:0] = count;
                timer_pkg::CONST_A_ADDR: next_rdata[7:0] = const_a;
                timer_pkg::CONST_B_ADDR: next_rdata[7:0] = const_b;
                timer_pkg::ALT_ADDR: next_rdata[0] = alt;
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            control <= timer_pkg::CTRL_RESET;
            alt <= 1'b0;
            out_sel <= timer_pkg::OUT_SEL_RESET;
            count <= timer_pkg::COUNT_RESET;
            const_a <= timer_pkg::CONST_RESET;
            const_b <= timer_pkg::CONST_RESET;
            flags <= 3'h0;
            armed <= 3'h0;
            eq_a_q <= 1'b0;
            eq_b_q <= 1'b0;
            pin_level <= 1'b0;
            timer_out_o <= 1'b0;
            timer_out_oe_n_o <= 1'b1;
            irq_overflow_o <= 1'b0;
            irq_compare_a_o <= 1'b0;
            irq_compare_b_o <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            control <= next_control;
            alt <= next_alt;
            out_sel <= next_out_sel;
            count <= next_count;
            const_a <= next_const_a;
            const_b <= next_const_b;
            flags <= next_flags;
            armed <= next_armed;
            eq_a_q <= eq_a;
            eq_b_q <= eq_b;
            pin_level <= next_pin_level;
            timer_out_o <= next_pin_level;
            timer_out_oe_n_o <= (next_out_sel == 4'h0);
            irq_overflow_o <= next_flags[timer_pkg::FLAG_OVF]
                && next_control[timer_pkg::OVF_IE_BIT];
            irq_compare_a_o <= next_flags[timer_pkg::FLAG_A]
                && next_control[timer_pkg::CMP_A_IE_BIT];
            irq_compare_b_o <= next_flags[timer_pkg::FLAG_B]
                && next_control[timer_pkg::CMP_B_IE_BIT];
            wb_ack_o <= next_ack;
            wb_dat_o <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    stopped_holds_a: assert property ((src == 3'h0 || src == 3'h4) && !clr
        && !cnt_wr |=> count == $past(count))
        else $error("counter moved while stopped");
    ext_rise_inc_a: assert property (src == timer_pkg::SRC_EXT_RISE
        && ext_rise && !clr && !cnt_wr
        |=> count == 8'($past(count) + 8'h01))
        else $error("no count on external rising edge");
    ext_fall_inc_a: assert property (src == timer_pkg::SRC_EXT_FALL
        && ext_fall && !clr && !cnt_wr
        |=> count == 8'($past(count) + 8'h01))
        else $error("no count on external falling edge");
    both_edge_inc_a: assert property (src == timer_pkg::SRC_EXT_BOTH
        && (ext_rise || ext_fall) && !clr && !cnt_wr
        |=> count == 8'($past(count) + 8'h01))
        else $error("no count on external edge");
    no_clear_a: assert property (clr_sel == timer_pkg::CLR_NONE
        && !tick && !cnt_wr |=> count == $past(count))
        else $error("counter changed without cause");
    clear_a_a: assert property (clr_sel == timer_pkg::CLR_ON_A
        && match_a && !cnt_wr |=> count == 8'h00)
        else $error("match A did not clear counter");
    clear_b_a: assert property (clr_sel == timer_pkg::CLR_ON_B
        && match_b && !cnt_wr |=> count == 8'h00)
        else $error("match B did not clear counter");
    clear_pin_a: assert property (clr_sel == timer_pkg::CLR_ON_PIN
        && rst_rise && !cnt_wr |=> count == 8'h00)
        else $error("reset pin did not clear counter");
    ovf_irq_gate_a: assert property (!control[timer_pkg::OVF_IE_BIT]
        && !next_control[timer_pkg::OVF_IE_BIT] |=> !irq_overflow_o)
        else $error("overflow request while disabled");
    flag_a_set_a: assert property ($rose(flags[timer_pkg::FLAG_A])
        |-> $past(match_a))
        else $error("flag A set without match");
    toggle_a_a: assert property (act_a == timer_pkg::ACT_TOGGLE && match_a
        && !match_b |=> timer_out_o != $past(pin_level))
        else $error("output did not toggle on match A");
    out_off_a: assert property (out_sel == 4'h0 && !wr
        |=> timer_out_oe_n_o)
        else $error("pin driven with output disabled");
    ovf_set_a: assert property (set_evt[timer_pkg::FLAG_OVF]
        |=> flags[timer_pkg::FLAG_OVF] && count == 8'h00)
        else $error("wrap did not set overflow flag");
endmodule : compare_timer
`default_nettype wire

// [bench/ext_pins_model.sv]
// pins around the timer channel: count clock, counter reset, output pin
// assumes the bench calls its tasks from its clocked sequence
`timescale 1ns/100ps
`default_nettype none
module ext_pins_model
(
    input wire logic clk_i,
    input wire logic timer_out_i,
    input wire logic timer_out_oe_n_i,
    output logic ext_clk_o,
    output logic ext_reset_o,
    output logic pin_level_o
);
    // pulled up while the timer leaves the pin
    assign pin_level_o = timer_out_oe_n_i ? 1'b1 : timer_out_i;
    initial
    begin
        ext_clk_o = 1'b0;
        ext_reset_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // clock pulses, six cycles per phase, idle low between
    task automatic clk_pulses(input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            ext_clk_o <= 1'b1;
            repeat (6) @(posedge clk_i);
            ext_clk_o <= 1'b0;
            repeat (5) @(posedge clk_i);
        end
    endtask : clk_pulses
    // one counter reset pulse
    task automatic reset_pulse;
        @(posedge clk_i);
        ext_reset_o <= 1'b1;
        repeat (6) @(posedge clk_i);
        ext_reset_o <= 1'b0;
    endtask : reset_pulse
endmodule : ext_pins_model
`default_nettype wire

// [bench/compare_timer_bench.sv]
// self-checking bench of the compare timer channel
// assumes the timer package and the pin model are compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("mismatch %s expected %h seen %h", nm, exp, got); \
        end \
    end
module compare_timer_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [3:0] bsel = 4'hF;
    logic [7:0] cadr;
    logic [31:0] wdat = 32'h00000000;
    wire [31:0] rdat;
    wire ack, tout, toe_n, irq_ov, irq_a, irq_b, ext_clk, ext_rst, pin;
    int mismatches = 0;
    int n_compared = 0;
    int cyc_cnt = 0;
    int t_ack = 0;
    int t0;
    logic [7:0] q;
    logic [7:0] c0;
    logic ok;
    logic [7:0] reg_adr [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
        8'h18};
    logic [7:0] reg_rst [7] = '{8'h00, 8'h10, 8'h00, 8'hFF, 8'hFF, 8'h00,
        8'h00};
    logic [3:0] pre_mode [8] = '{4'h1, 4'h2, 4'h3, 4'h0, 4'h9, 4'hA, 4'hB,
        4'hC};
    int pre_div [8] = '{8, 64, 1024, 0, 2, 32, 256, 0};
    logic [3:0] act_sel [7] = '{4'h2, 4'h1, 4'h3, 4'h4, 4'h4, 4'h8, 4'hC};
    logic act_b [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    logic act_pin [7] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) cyc_cnt <= cyc_cnt + 1;
    compare_timer u_compare_timer
    (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .ext_clk_i(ext_clk),
        .ext_reset_i(ext_rst), .timer_out_o(tout), .timer_out_oe_n_o(toe_n),
        .irq_overflow_o(irq_ov), .irq_compare_a_o(irq_a),
        .irq_compare_b_o(irq_b)
    );
    ext_pins_model u_ext_pins_model
    (
        .clk_i(clk_i), .timer_out_i(tout), .timer_out_oe_n_i(toe_n),
        .ext_clk_o(ext_clk), .ext_reset_o(ext_rst), .pin_level_o(pin)
    );
    ////////////////////////////////////////////////////////////////////////
    // one classic bus cycle, held until ack is sampled
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= bsel;
        wdat <= {24'h000000, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 40);
        `CHK("bus ack", 1'b1, ack)
        q = rdat[7:0];
        t_ack = cyc_cnt;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        xfer(1'b0, a, 8'h00);
    endtask : rd
    task automatic chk_count(input logic [7:0] e);
        rd(timer_pkg::COUNT_ADDR);
        `CHK("count", e, q)
    endtask : chk_count
    // arm then clear all flags, load count and control
    task automatic setup(input logic [7:0] ctl, input logic [7:0] cnt);
        rd(timer_pkg::STAT_ADDR);
        wr(timer_pkg::STAT_ADDR, 8'h00);
        wr(timer_pkg::COUNT_ADDR, cnt);
        wr(timer_pkg::CTRL_ADDR, ctl);
    endtask : setup
    task automatic print_verdict;
        if (mismatches == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (40000) @(posedge clk_i);
        mismatches++;
        print_verdict;
    end
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        `CHK("oe_n", 1'b1, toe_n)
        `CHK("irqs", 3'h0, {irq_ov, irq_a, irq_b})
        for (int i = 0; i < 7; i++)
        begin
            rd(reg_adr[i]);
            `CHK("reset value", reg_rst[i], q)
        end
        wr(8'h18, 8'hFF);
        rd(8'h18);
        `CHK("unmapped", 8'h00, q)
        // write without the low byte lane is ignored
        bsel = 4'hE;
        wr(timer_pkg::CONST_A_ADDR, 8'h12);
        bsel = 4'hF;
        rd(timer_pkg::CONST_A_ADDR);
        `CHK("masked write", 8'hFF, q)
        // prescaled sources and stopped codes
        for (int i = 0; i < 8; i++)
        begin
            wr(timer_pkg::ALT_ADDR, {7'h00, pre_mode[i][3]});
            wr(timer_pkg::CTRL_ADDR, {5'h00, pre_mode[i][2:0]});
            rd(timer_pkg::COUNT_ADDR);
            c0 = q;
            t0 = t_ack;
            repeat (pre_div[i] == 0 ? 64 : 4 * pre_div[i]) @(posedge clk_i);
            rd(timer_pkg::COUNT_ADDR);
            c0 = q - c0;
            if (pre_div[i] == 0)
                ok = (c0 == 8'h00);
            else
                ok = (int'(c0) == (t_ack - t0) / pre_div[i]) ||
                     (int'(c0) == (t_ack - t0) / pre_div[i] + 1);
            `CHK("prescaled count", 1'b1, ok)
        end
        // external clock edges
        for (int i = 5; i < 8; i++)
        begin
            wr(timer_pkg::CTRL_ADDR, {5'h00, 3'(i)});
            rd(timer_pkg::COUNT_ADDR);
            c0 = q;
            u_ext_pins_model.clk_pulses(3);
            repeat (8) @(posedge clk_i);
            rd(timer_pkg::COUNT_ADDR);
            c0 = q - c0;
            `CHK("edge count", (i == 7) ? 8'h06 : 8'h03, c0)
        end
        // clear on match A
        wr(timer_pkg::CONST_A_ADDR, 8'h05);
        setup(8'h4D, 8'h00);
        u_ext_pins_model.clk_pulses(5);
        repeat (8) @(posedge clk_i);
        chk_count(8'h00);
        `CHK("irq a", 1'b1, irq_a)
        rd(timer_pkg::STAT_ADDR);
        `CHK("flag a", 1'b1, q[6])
        wr(timer_pkg::STAT_ADDR, 8'h00);
        rd(timer_pkg::STAT_ADDR);
        `CHK("flag a", 1'b0, q[6])
        `CHK("irq a", 1'b0, irq_a)
        // clear on match B
        wr(timer_pkg::CONST_B_ADDR, 8'h03);
        setup(8'h95, 8'h00);
        u_ext_pins_model.clk_pulses(3);
        repeat (8) @(posedge clk_i);
        chk_count(8'h00);
        `CHK("irq b", 1'b1, irq_b)
        rd(timer_pkg::STAT_ADDR);
        `CHK("flag b", 1'b1, q[7])
        // no clear, requests disabled
        wr(timer_pkg::CONST_A_ADDR, 8'h02);
        setup(8'h05, 8'h00);
        u_ext_pins_model.clk_pulses(4);
        repeat (8) @(posedge clk_i);
        chk_count(8'h04);
        `CHK("irq a b", 2'h0, {irq_a, irq_b})
        // clear by reset pin
        setup(8'h1D, 8'h00);
        u_ext_pins_model.clk_pulses(4);
        repeat (8) @(posedge clk_i);
        chk_count(8'h04);
        u_ext_pins_model.reset_pulse;
        repeat (8) @(posedge clk_i);
        chk_count(8'h00);
        // overflow
        setup(8'h25, 8'hFF);
        u_ext_pins_model.clk_pulses(1);
        repeat (8) @(posedge clk_i);
        chk_count(8'h00);
        `CHK("irq overflow", 1'b1, irq_ov)
        rd(timer_pkg::STAT_ADDR);
        `CHK("overflow flag", 1'b1, q[5])
        // output actions, matches made by constant writes
        setup(8'h00, 8'h40);
        for (int i = 0; i < 7; i++)
        begin
            wr(timer_pkg::STAT_ADDR, {4'h0, act_sel[i]});
            cadr = act_b[i] ? timer_pkg::CONST_B_ADDR : timer_pkg::CONST_A_ADDR;
            wr(cadr, 8'h41);
            wr(cadr, 8'h40);
            repeat (2) @(posedge clk_i);
            `CHK("pin level", act_pin[i], pin)
            `CHK("oe_n", 1'b0, toe_n)
        end
        wr(timer_pkg::STAT_ADDR, 8'h00);
        repeat (2) @(posedge clk_i);
        `CHK("oe_n", 1'b1, toe_n)
        rd(timer_pkg::STAT_ADDR);
        `CHK("status", 8'hD0, q)
        wr(timer_pkg::STAT_ADDR, 8'h00);
        rd(timer_pkg::STAT_ADDR);
        `CHK("status", 8'h10, q)
        wr(timer_pkg::STAT_ADDR, 8'hE0);
        rd(timer_pkg::STAT_ADDR);
        `CHK("status", 8'h10, q)
        print_verdict;
    end
endmodule : compare_timer_bench
`default_nettype wire
